// ===== rtl/snd_pkg.sv
// Constants, opcodes and state types of the serial nvSRAM instruction decoder
package snd_pkg;
	localparam int CLK_PERIOD_NS          = 4;
	localparam int RESTORE_INTERVAL_NS    = 8000;
	localparam int NV_SAVE_TIME_NS        = 8000;
	localparam int NV_RESTORE_TIME_NS     = 4000;
	localparam int STANDBY_ENTRY_DELAY_NS = 100;
	localparam int WRITE_DRAIN_TIME_NS    = 500;
	localparam int CNT_W                  = 12;
	localparam logic [CNT_W-1:0] RESTORE_CNT =
		CNT_W'((RESTORE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] NV_SAVE_CNT =
		CNT_W'((NV_SAVE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] NV_RESTORE_CNT =
		CNT_W'((NV_RESTORE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] STANDBY_CNT =
		CNT_W'((STANDBY_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] WRITE_DRAIN_CNT =
		CNT_W'((WRITE_DRAIN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
	localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

	localparam logic [7:0] STATUS_READ_OP          = 8'h05;
	localparam logic [7:0] STATUS_READ_FAST_OP     = 8'h09;
	localparam logic [7:0] STATUS_WRITE_OP         = 8'h01;
	localparam logic [7:0] WRITE_LATCH_SET_OP      = 8'h06;
	localparam logic [7:0] WRITE_LATCH_CLEAR_OP    = 8'h04;
	localparam logic [7:0] MEM_READ_OP             = 8'h03;
	localparam logic [7:0] MEM_READ_FAST_OP        = 8'h0b;
	localparam logic [7:0] MEM_WRITE_OP            = 8'h02;
	localparam logic [7:0] CLOCK_REGS_READ_OP      = 8'h13;
	localparam logic [7:0] CLOCK_REGS_READ_FAST_OP = 8'h1d;
	localparam logic [7:0] CLOCK_REGS_WRITE_OP     = 8'h12;
	localparam logic [7:0] NV_SAVE_OP              = 8'h3c;
	localparam logic [7:0] NV_RESTORE_OP           = 8'h60;
	localparam logic [7:0] AUTO_SAVE_ON_OP         = 8'h59;
	localparam logic [7:0] AUTO_SAVE_OFF_OP        = 8'h19;
	localparam logic [7:0] SLEEP_OP                = 8'hb9;
	localparam logic [7:0] SERIAL_NO_WRITE_OP      = 8'hc2;
	localparam logic [7:0] SERIAL_NO_READ_OP       = 8'hc3;
	localparam logic [7:0] SERIAL_NO_READ_FAST_OP  = 8'hc9;
	localparam logic [7:0] IDENT_READ_OP           = 8'h9f;
	localparam logic [7:0] IDENT_READ_FAST_OP      = 8'h99;

	// Nonvolatile copy layout: auto save enable, pin enable, guard hi, guard lo
	localparam int NV_AUTO_BIT   = 3;
	localparam int NV_PIN_EN_BIT = 2;
	localparam int NV_HI_BIT     = 1;
	localparam int NV_LO_BIT     = 0;
	localparam logic [3:0] NV_RST = 4'h8;
	// Status byte positions
	localparam int ST_PIN_EN_BIT = 7;
	localparam int ST_HI_BIT     = 3;
	localparam int ST_LO_BIT     = 2;

	localparam int SY_CS   = 0;
	localparam int SY_SCK  = 1;
	localparam int SY_SI   = 2;
	localparam int SY_HOLD = 3;
	localparam int SY_PWR  = 4;
	localparam int SYNC_W  = 5;

	typedef enum logic [3:0] {
		CLS_NONE, CLS_STATUS_READ, CLS_STATUS_WRITE, CLS_LATCH_SET, CLS_LATCH_CLEAR,
		CLS_MEM_READ, CLS_MEM_WRITE, CLS_CLOCK_READ, CLS_CLOCK_WRITE, CLS_NV_SAVE,
		CLS_NV_RESTORE, CLS_AUTO_ON, CLS_AUTO_OFF, CLS_SLEEP, CLS_SERIAL_READ,
		CLS_SERIAL_WRITE_OR_IDENT
	} snd_cls_t;

	typedef enum logic [1:0] {
		FRM_IDLE = 2'b00, FRM_OPCODE = 2'b01, FRM_BODY = 2'b11, FRM_IGNORE = 2'b10
	} snd_frm_t;

	typedef enum logic [2:0] {
		PWR_OFF = 3'b000, PWR_RESTORE = 3'b001, PWR_READY = 3'b011,
		PWR_DRAIN = 3'b010, PWR_SAVE = 3'b110
	} snd_pwr_t;
endpackage

// ===== rtl/snd_sync.sv
// Two-flop synchroniser for a group of asynchronous inputs
module snd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         rstn_in,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			meta_r   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_r   <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// ===== rtl/snd_decoder.sv
// Serial nvSRAM instruction decoder with power-state and save/restore sequencing
// Operation
// - Supply up starts restore for the restore interval; memory accesses refused meanwhile.
// - After power-up, chip select low means active, high means standby.
// - After power-up the hold pause is cleared.
// - Power-up clears the write-enable latch.
// - Pin-enable and both block-guard bits restore from the last save.
// - Below the supply threshold no instruction is answered.
// - A write whose last data bit arrived gets its completion delay first.
// - Power-down save runs only if something was written since the last restore.
// - Chip select low is active; high enters standby after the entry delay.
// - Standby entry waits for a running save or restore to finish.
// - The save-busy pin shows ready or busy after power-up.
// - Eight-bit instruction register; everything shifts most significant bit first.
// - Decode status read, fast status read and status write opcodes.
// - Write-latch-set opcode sets the write-enable latch.
// - Write-latch-clear opcode clears the write-enable latch.
// - Decode memory read, fast memory read and memory write opcodes.
// - Decode clock register read, fast read and write opcodes.
// - Save opcode starts a software save; restore opcode a software restore.
// - Auto save on and off opcodes control the power-loss save.
// - Sleep opcode enters sleep mode.
// - Decode serial number write, read and fast read opcodes.
// - Ident read opcodes return the identifier bytes.
// - Unknown opcode: ignore input until next chip select fall, output off.
// - One opcode per chip select low period; each starts at the fall.
// - Mode from clock level at select; sample on rise, drive on fall.
// - Write-type and nonvolatile instructions clear the latch when they complete.
module snd_decoder
	import snd_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       power_good_in,
	input  wire logic       cs_n_in,
	input  wire logic       sck_in,
	input  wire logic       si_in,
	input  wire logic       hold_n_in,
	input  wire logic [7:0] read_byte_in,
	output logic            so_out,
	output logic            so_oe_out,
	output logic            hardware_save_busy_pin_n_out,
	output logic            power_ready_out,
	output logic            active_mode_out,
	output logic            standby_out,
	output logic            hold_out,
	output logic            sleep_out,
	output logic            spi_mode3_out,
	output logic            write_latch_out,
	output logic            auto_save_en_out,
	output logic            protect_pin_enable_bit_out,
	output logic            block_guard_hi_bit_out,
	output logic            block_guard_lo_bit_out,
	output snd_cls_t        op_class_out,
	output logic [7:0]      opcode_out,
	output logic            op_start_out,
	output logic            op_refused_out,
	output logic [7:0]      rx_byte_out,
	output logic            rx_valid_out,
	output logic [1:0]      rx_index_out,
	output logic            read_take_out,
	output logic            frame_end_out
);
	logic [SYNC_W-1:0] sync_s;
	logic              cs_prev_r;
	logic              sck_prev_r;
	snd_frm_t          frm_r;
	snd_pwr_t          pwr_r;
	logic [CNT_W-1:0]  pwr_cnt_r;
	logic [CNT_W-1:0]  sw_cnt_r;
	logic [CNT_W-1:0]  sb_cnt_r;
	logic              sw_is_save_r;
	logic [2:0]        bit_cnt_r;
	logic [6:0]        sh_r;
	logic [1:0]        byte_cnt_r;
	logic [7:0]        tx_r;
	logic [3:0]        nv_r;
	logic [3:0]        vol_r;
	logic              dirty_r;

	snd_sync #(
		.W(SYNC_W)
	) u_sync (
		.clk_in  (clk_in),
		.rstn_in (rstn_in),
		.async_in({power_good_in, hold_n_in, si_in, sck_in, cs_n_in}),
		.sync_out(sync_s)
	);

	logic cs_n_s;
	logic sck_s;
	logic pwr_s;
	assign cs_n_s = sync_s[SY_CS];
	assign sck_s  = sync_s[SY_SCK];
	assign pwr_s  = sync_s[SY_PWR];

	logic cs_fall;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic link_on;
	logic sw_busy;
	logic busy;
	logic byte_done;
	logic [7:0] rx_byte;
	snd_cls_t  cls_now;
	logic      write_cls;
	logic      mem_cls;
	logic      read_cls;
	logic      is_fast;
	logic [1:0] data_first;
	logic      wr_landed;
	logic      frame_done;
	logic      save_done;
	logic      restore_start;
	logic      sw_restore_done;

	assign cs_fall   = cs_prev_r & ~cs_n_s;
	assign cs_rise   = ~cs_prev_r & cs_n_s;
	assign sck_rise  = ~sck_prev_r & sck_s & ~hold_out;
	assign sck_fall  = sck_prev_r & ~sck_s & ~hold_out;
	assign link_on   = (pwr_r == PWR_RESTORE) || (pwr_r == PWR_READY);
	assign sw_busy   = (sw_cnt_r != CNT_ZERO);
	assign busy      = (pwr_r != PWR_READY) || sw_busy;
	assign byte_done = sck_rise && (bit_cnt_r == 3'h7);
	assign rx_byte   = {sh_r, sync_s[SY_SI]};
	assign frame_done = cs_rise && (frm_r == FRM_BODY);

	// Opcode classification of the byte just completed or of the running frame
	function automatic snd_cls_t classify(input logic [7:0] op);
		case (op)
			STATUS_READ_OP, STATUS_READ_FAST_OP:       classify = CLS_STATUS_READ;
			STATUS_WRITE_OP:                           classify = CLS_STATUS_WRITE;
			WRITE_LATCH_SET_OP:                        classify = CLS_LATCH_SET;
			WRITE_LATCH_CLEAR_OP:                      classify = CLS_LATCH_CLEAR;
			MEM_READ_OP, MEM_READ_FAST_OP:             classify = CLS_MEM_READ;
			MEM_WRITE_OP:                              classify = CLS_MEM_WRITE;
			CLOCK_REGS_READ_OP, CLOCK_REGS_READ_FAST_OP: classify = CLS_CLOCK_READ;
			CLOCK_REGS_WRITE_OP:                       classify = CLS_CLOCK_WRITE;
			NV_SAVE_OP:                                classify = CLS_NV_SAVE;
			NV_RESTORE_OP:                             classify = CLS_NV_RESTORE;
			AUTO_SAVE_ON_OP:                           classify = CLS_AUTO_ON;
			AUTO_SAVE_OFF_OP:                          classify = CLS_AUTO_OFF;
			SLEEP_OP:                                  classify = CLS_SLEEP;
			SERIAL_NO_READ_OP, SERIAL_NO_READ_FAST_OP,
			IDENT_READ_OP, IDENT_READ_FAST_OP:         classify = CLS_SERIAL_READ;
			SERIAL_NO_WRITE_OP:                        classify = CLS_SERIAL_WRITE_OR_IDENT;
			default:                                   classify = CLS_NONE;
		endcase
	endfunction

	function automatic logic needs_latch(input snd_cls_t c);
		case (c)
			CLS_STATUS_WRITE, CLS_MEM_WRITE, CLS_CLOCK_WRITE, CLS_SERIAL_WRITE_OR_IDENT,
			CLS_NV_SAVE, CLS_NV_RESTORE, CLS_AUTO_ON, CLS_AUTO_OFF: needs_latch = 1'b1;
			default: needs_latch = 1'b0;
		endcase
	endfunction

	assign cls_now   = classify(rx_byte);
	assign write_cls = (op_class_out == CLS_STATUS_WRITE) || (op_class_out == CLS_MEM_WRITE)
		|| (op_class_out == CLS_CLOCK_WRITE) || (op_class_out == CLS_SERIAL_WRITE_OR_IDENT);
	assign mem_cls   = (cls_now == CLS_MEM_READ) || (cls_now == CLS_MEM_WRITE)
		|| (cls_now == CLS_CLOCK_READ) || (cls_now == CLS_CLOCK_WRITE)
		|| (cls_now == CLS_SERIAL_READ) || (cls_now == CLS_SERIAL_WRITE_OR_IDENT);
	assign read_cls  = (op_class_out == CLS_STATUS_READ) || (op_class_out == CLS_MEM_READ)
		|| (op_class_out == CLS_CLOCK_READ) || (op_class_out == CLS_SERIAL_READ);
	assign is_fast   = (opcode_out == STATUS_READ_FAST_OP);
	assign data_first = (op_class_out == CLS_MEM_WRITE) ? 2'h3
		: (op_class_out == CLS_CLOCK_WRITE) ? 2'h2 : 2'h1;
	// Write frame sitting on a byte boundary with data already in
	assign wr_landed = (frm_r == FRM_BODY) && write_cls && (bit_cnt_r == 3'h0)
		&& (byte_cnt_r >= data_first) && !cs_n_s;
	assign save_done = ((pwr_r == PWR_SAVE) && (pwr_cnt_r == CNT_ONE))
		|| (sw_is_save_r && (sw_cnt_r == CNT_ONE));
	assign restore_start   = (pwr_r == PWR_OFF) && pwr_s;
	assign sw_restore_done = !sw_is_save_r && (sw_cnt_r == CNT_ONE);

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cs_prev_r  <= 1'b1;
			sck_prev_r <= 1'b0;
		end
		else
		begin
			cs_prev_r  <= cs_n_s;
			sck_prev_r <= sck_s;
		end
	end

	// Supply sequencing: restore on rise, drain and conditional save on decay
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			pwr_r     <= PWR_OFF;
			pwr_cnt_r <= CNT_ZERO;
		end
		else
		begin
			case (pwr_r)
				PWR_OFF:
				begin
					if (pwr_s)
					begin
						pwr_r     <= PWR_RESTORE;
						pwr_cnt_r <= RESTORE_CNT;
					end
				end
				PWR_RESTORE:
				begin
					if (!pwr_s)
						pwr_r <= PWR_OFF;
					else if (pwr_cnt_r == CNT_ONE)
						pwr_r <= PWR_READY;
					pwr_cnt_r <= pwr_cnt_r - CNT_ONE;
				end
				PWR_READY:
				begin
					if (!pwr_s && wr_landed)
					begin
						pwr_r     <= PWR_DRAIN;
						pwr_cnt_r <= WRITE_DRAIN_CNT;
					end
					else if (!pwr_s && vol_r[NV_AUTO_BIT] && dirty_r)
					begin
						pwr_r     <= PWR_SAVE;
						pwr_cnt_r <= NV_SAVE_CNT;
					end
					else if (!pwr_s)
						pwr_r <= PWR_OFF;
				end
				PWR_DRAIN:
				begin
					pwr_cnt_r <= pwr_cnt_r - CNT_ONE;
					if (pwr_cnt_r == CNT_ONE)
					begin
						pwr_r     <= (vol_r[NV_AUTO_BIT] && dirty_r) ? PWR_SAVE : PWR_OFF;
						pwr_cnt_r <= NV_SAVE_CNT;
					end
				end
				PWR_SAVE:
				begin
					pwr_cnt_r <= pwr_cnt_r - CNT_ONE;
					if (pwr_cnt_r == CNT_ONE)
						pwr_r <= PWR_OFF;
				end
				default:
					pwr_r <= PWR_OFF;
			endcase
		end
	end

	// Software save and restore cycles, started when their frame ends
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sw_cnt_r     <= CNT_ZERO;
			sw_is_save_r <= 1'b0;
		end
		else if (pwr_r != PWR_READY)
			sw_cnt_r <= CNT_ZERO;
		else if (frame_done && (op_class_out == CLS_NV_SAVE))
		begin
			sw_cnt_r     <= NV_SAVE_CNT;
			sw_is_save_r <= 1'b1;
		end
		else if (frame_done && (op_class_out == CLS_NV_RESTORE))
		begin
			sw_cnt_r     <= NV_RESTORE_CNT;
			sw_is_save_r <= 1'b0;
		end
		else if (sw_busy)
			sw_cnt_r <= sw_cnt_r - CNT_ONE;
	end

	// Nonvolatile copy and its working bits
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			nv_r    <= NV_RST;
			vol_r   <= NV_RST;
			dirty_r <= 1'b0;
		end
		else
		begin
			if (save_done)
				nv_r <= vol_r;
			if (restore_start || sw_restore_done)
			begin
				vol_r   <= nv_r;
				dirty_r <= 1'b0;
			end
			else
			begin
				if (rx_valid_out && (op_class_out == CLS_STATUS_WRITE) && (rx_index_out == 2'h0))
				begin
					vol_r[NV_PIN_EN_BIT] <= rx_byte_out[ST_PIN_EN_BIT];
					vol_r[NV_HI_BIT]     <= rx_byte_out[ST_HI_BIT];
					vol_r[NV_LO_BIT]     <= rx_byte_out[ST_LO_BIT];
				end
				if (frame_done && (op_class_out == CLS_AUTO_ON))
					vol_r[NV_AUTO_BIT] <= 1'b1;
				if (frame_done && (op_class_out == CLS_AUTO_OFF))
					vol_r[NV_AUTO_BIT] <= 1'b0;
			end
			// Write data landing with a restore still marks the copy dirty
			if (rx_valid_out && write_cls && (rx_index_out >= data_first - 2'h1))
				dirty_r <= 1'b1;
		end
	end

	// Write-enable latch: set on its opcode, cleared at the end of guarded frames
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			write_latch_out <= 1'b0;
		else if (!link_on)
			write_latch_out <= 1'b0;
		else if (byte_done && (frm_r == FRM_OPCODE) && (cls_now == CLS_LATCH_SET))
			write_latch_out <= 1'b1;
		else if (frame_done && (needs_latch(op_class_out) || op_class_out == CLS_LATCH_CLEAR))
			write_latch_out <= 1'b0;
	end

	// Frame sequencing, opcode capture and body bytes
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			frm_r          <= FRM_IDLE;
			bit_cnt_r      <= 3'h0;
			sh_r           <= 7'h00;
			byte_cnt_r     <= 2'h0;
			spi_mode3_out  <= 1'b0;
			op_class_out   <= CLS_NONE;
			opcode_out     <= 8'h00;
			op_start_out   <= 1'b0;
			op_refused_out <= 1'b0;
			rx_byte_out    <= 8'h00;
			rx_valid_out   <= 1'b0;
			rx_index_out   <= 2'h0;
			frame_end_out  <= 1'b0;
		end
		else
		begin
			op_start_out   <= 1'b0;
			op_refused_out <= 1'b0;
			rx_valid_out   <= 1'b0;
			frame_end_out  <= frame_done;
			if (!link_on || cs_rise)
				frm_r <= FRM_IDLE;
			else if (cs_fall)
			begin
				frm_r         <= FRM_OPCODE;
				bit_cnt_r     <= 3'h0;
				byte_cnt_r    <= 2'h0;
				spi_mode3_out <= sck_s;
			end
			else if (sck_rise && (frm_r != FRM_IDLE) && (frm_r != FRM_IGNORE))
			begin
				sh_r      <= rx_byte[6:0];
				bit_cnt_r <= bit_cnt_r + 3'h1;
				if (byte_done && (frm_r == FRM_OPCODE))
				begin
					opcode_out   <= rx_byte;
					op_class_out <= cls_now;
					if (cls_now == CLS_NONE)
						frm_r <= FRM_IGNORE;
					else if ((needs_latch(cls_now) && !write_latch_out) || (mem_cls && busy))
					begin
						frm_r          <= FRM_IGNORE;
						op_refused_out <= 1'b1;
					end
					else
					begin
						frm_r        <= FRM_BODY;
						op_start_out <= 1'b1;
					end
				end
				else if (byte_done)
				begin
					rx_byte_out  <= rx_byte;
					rx_valid_out <= 1'b1;
					rx_index_out <= byte_cnt_r;
					if (byte_cnt_r != 2'h3)
						byte_cnt_r <= byte_cnt_r + 2'h1;
				end
			end
		end
	end

	// Serial output: loads a byte on the first falling edge of each byte slot
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			so_out        <= 1'b0;
			so_oe_out     <= 1'b0;
			tx_r          <= 8'h00;
			read_take_out <= 1'b0;
		end
		else
		begin
			read_take_out <= 1'b0;
			so_oe_out     <= (frm_r == FRM_BODY) && read_cls && !cs_n_s;
			if (sck_fall && (frm_r == FRM_BODY) && read_cls)
			begin
				if (bit_cnt_r == 3'h0)
				begin
					if (op_class_out != CLS_STATUS_READ)
					begin
						so_out        <= read_byte_in[7];
						tx_r          <= {read_byte_in[6:0], 1'b0};
						read_take_out <= 1'b1;
					end
					else if (is_fast && (byte_cnt_r == 2'h0))
					begin
						so_out <= 1'b0;
						tx_r   <= 8'h00;
					end
					else
					begin
						so_out <= vol_r[NV_PIN_EN_BIT];
						tx_r   <= {3'b000, vol_r[NV_HI_BIT], vol_r[NV_LO_BIT],
							write_latch_out, busy, 1'b0};
					end
				end
				else
				begin
					so_out <= tx_r[7];
					tx_r   <= {tx_r[6:0], 1'b0};
				end
			end
		end
	end

	// Power mode, hold, sleep and pin indications
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sb_cnt_r                     <= STANDBY_CNT;
			standby_out                  <= 1'b0;
			active_mode_out              <= 1'b0;
			hold_out                     <= 1'b0;
			sleep_out                    <= 1'b0;
			hardware_save_busy_pin_n_out <= 1'b0;
			power_ready_out              <= 1'b0;
		end
		else
		begin
			active_mode_out              <= link_on && !cs_n_s;
			hardware_save_busy_pin_n_out <= !busy;
			power_ready_out              <= (pwr_r == PWR_READY);
			hold_out <= link_on && !restore_start && (pwr_r != PWR_RESTORE || pwr_cnt_r != RESTORE_CNT)
				&& !cs_n_s && !sync_s[SY_HOLD];
			if (!link_on || !cs_n_s)
			begin
				sb_cnt_r    <= STANDBY_CNT;
				standby_out <= 1'b0;
			end
			else if (busy)
				sb_cnt_r <= STANDBY_CNT;
			else if (sb_cnt_r == CNT_ONE)
				standby_out <= 1'b1;
			else
				sb_cnt_r <= sb_cnt_r - CNT_ONE;
			if (!link_on || cs_fall)
				sleep_out <= 1'b0;
			else if (frame_done && (op_class_out == CLS_SLEEP))
				sleep_out <= 1'b1;
		end
	end

	assign auto_save_en_out           = vol_r[NV_AUTO_BIT];
	assign protect_pin_enable_bit_out = vol_r[NV_PIN_EN_BIT];
	assign block_guard_hi_bit_out     = vol_r[NV_HI_BIT];
	assign block_guard_lo_bit_out     = vol_r[NV_LO_BIT];
endmodule

// ===== testbench/snd_decoder_monitor.sv
// Port-level checks of the instruction decoder
module snd_decoder_monitor
	import snd_pkg::*;
(
	input wire logic     clk_in,
	input wire logic     rstn_in,
	input wire logic     power_good_in,
	input wire logic     cs_n_in,
	input wire logic     so_oe_out,
	input wire logic     hardware_save_busy_pin_n_out,
	input wire logic     power_ready_out,
	input wire logic     active_mode_out,
	input wire logic     standby_out,
	input wire logic     hold_out,
	input wire logic     sleep_out,
	input wire logic     write_latch_out,
	input wire snd_cls_t op_class_out,
	input wire logic [7:0] opcode_out,
	input wire logic     op_start_out,
	input wire logic     frame_end_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	logic [7:0] hi_cnt_r;
	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			hi_cnt_r <= 8'h00;
		else
			hi_cnt_r <= !cs_n_in ? 8'h00 : (hi_cnt_r == 8'hff ? hi_cnt_r : hi_cnt_r + 8'h01);
	end
	property p_reset_clean;
		$rose(rstn_in) |-> !write_latch_out && !hold_out && !sleep_out;
	endproperty
	a_reset_clean: assert property (p_reset_clean) else $error("dirty state after reset");
	property p_restore_busy;
		$rose(power_ready_out) |-> !$past(hardware_save_busy_pin_n_out, 4);
	endproperty
	a_restore_busy: assert property (p_restore_busy) else $error("ready without restore");
	property p_no_answer_off;
		!power_good_in [*8] |-> !op_start_out;
	endproperty
	a_no_answer_off: assert property (p_no_answer_off) else $error("answer with power low");
	property p_standby_wait;
		$rose(standby_out) |-> hi_cnt_r >= 8'd25;
	endproperty
	a_standby_wait: assert property (p_standby_wait) else $error("standby too early");
	property p_standby_idle;
		$rose(standby_out) |-> hardware_save_busy_pin_n_out;
	endproperty
	a_standby_idle: assert property (p_standby_idle) else $error("standby while busy");
	property p_active_sel;
		!cs_n_in [*6] ##0 power_ready_out |-> active_mode_out && !standby_out;
	endproperty
	a_active_sel: assert property (p_active_sel) else $error("not active when selected");
	property p_latch_set;
		frame_end_out && opcode_out == WRITE_LATCH_SET_OP |-> write_latch_out;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latch not set");
	property p_latch_clear;
		frame_end_out && op_class_out inside {CLS_LATCH_CLEAR, CLS_STATUS_WRITE, CLS_MEM_WRITE,
			CLS_CLOCK_WRITE, CLS_NV_SAVE, CLS_NV_RESTORE, CLS_AUTO_ON, CLS_AUTO_OFF,
			CLS_SERIAL_WRITE_OR_IDENT} |-> ##[1:3] !write_latch_out;
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch not cleared");
	property p_oe_quiet;
		cs_n_in [*6] |-> !so_oe_out;
	endproperty
	a_oe_quiet: assert property (p_oe_quiet) else $error("output on when deselected");
	property p_dispatched;
		frame_end_out |-> op_class_out != CLS_NONE;
	endproperty
	a_dispatched: assert property (p_dispatched) else $error("frame without class");
	c_save: cover property (frame_end_out && op_class_out == CLS_NV_SAVE);
	c_standby: cover property ($rose(standby_out));
	c_ready: cover property ($rose(power_ready_out));
endmodule
bind snd_decoder snd_decoder_monitor snd_decoder_monitor_inst (.*);

// ===== testbench/snd_spi_master.sv
// Bus master model for the serial link, SCK half period six clocks
module snd_spi_master (
	input  wire logic clk_in,
	input  wire logic so_in,
	output logic      cs_n_out,
	output logic      sck_out,
	output logic      si_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] rx_r = 8'h00;
	initial
	begin
		cs_n_out = 1'b1;
		sck_out = 1'b0;
		si_out = 1'b0;
	end
	task automatic half();
		repeat (6) @(negedge clk_in);
	endtask
	// Opcode then n bytes of d; SCK rests at md outside the frame
	task automatic frame(input logic md, input logic [7:0] op, input int n, input logic [7:0] d);
		logic [7:0] b;
		sck_out = md;
		half();
		cs_n_out = 1'b0;
		half();
		for (int i = 0; i <= n; i++)
		begin
			b = (i == 0) ? op : d;
			for (int k = 7; k >= 0; k--)
			begin
				sck_out = 1'b0;
				si_out = b[k];
				half();
				sck_out = 1'b1;
				rx_r = {rx_r[6:0], so_in};
				half();
			end
		end
		sck_out = md;
		si_out = ~si_out;
		half();
		cs_n_out = 1'b1;
		half();
	endtask
endmodule

// ===== testbench/snd_decoder_tb.sv
// Self-checking bench of the instruction decoder
module snd_decoder_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import snd_pkg::*;
	typedef struct {logic [7:0] op; snd_cls_t c; logic w;} snd_row_t;
	logic clk_in = 1'b0, rstn_in = 1'b0, pg = 1'b1, hold_n = 1'b1;
	logic cs_n, sck, si, so, oe, hsb_n, rdy, act, stby, hold, slp, m3, wel, ase, pe, bhi, blo;
	logic st, rf;
	logic [7:0] opc;
	snd_cls_t cls;
	int n_mismatch = 0, compares = 0, cyc = 0, n_st = 0, n_rf = 0, n_oe = 0, n0;
	snd_row_t rows[21] = '{'{8'h05, CLS_STATUS_READ, 1'b1}, '{8'h09, CLS_STATUS_READ, 1'b1},
		'{8'h01, CLS_STATUS_WRITE, 1'b0}, '{8'h06, CLS_LATCH_SET, 1'b1},
		'{8'h04, CLS_LATCH_CLEAR, 1'b0}, '{8'h03, CLS_MEM_READ, 1'b1},
		'{8'h0b, CLS_MEM_READ, 1'b1}, '{8'h02, CLS_MEM_WRITE, 1'b0},
		'{8'h13, CLS_CLOCK_READ, 1'b1}, '{8'h1d, CLS_CLOCK_READ, 1'b1},
		'{8'h12, CLS_CLOCK_WRITE, 1'b0}, '{8'h3c, CLS_NV_SAVE, 1'b0},
		'{8'h60, CLS_NV_RESTORE, 1'b0}, '{8'h59, CLS_AUTO_ON, 1'b0},
		'{8'h19, CLS_AUTO_OFF, 1'b0}, '{8'hb9, CLS_SLEEP, 1'b1},
		'{8'hc2, CLS_SERIAL_WRITE_OR_IDENT, 1'b0}, '{8'hc3, CLS_SERIAL_READ, 1'b1},
		'{8'hc9, CLS_SERIAL_READ, 1'b1}, '{8'h9f, CLS_SERIAL_READ, 1'b1},
		'{8'h99, CLS_SERIAL_READ, 1'b1}};
	always #2 clk_in = ~clk_in;
	snd_decoder snd_decoder_inst (.clk_in(clk_in), .rstn_in(rstn_in), .power_good_in(pg),
		.cs_n_in(cs_n), .sck_in(sck), .si_in(si), .hold_n_in(hold_n), .read_byte_in(8'h3a),
		.so_out(so), .so_oe_out(oe), .hardware_save_busy_pin_n_out(hsb_n),
		.power_ready_out(rdy), .active_mode_out(act), .standby_out(stby), .hold_out(hold),
		.sleep_out(slp), .spi_mode3_out(m3), .write_latch_out(wel), .auto_save_en_out(ase),
		.protect_pin_enable_bit_out(pe), .block_guard_hi_bit_out(bhi),
		.block_guard_lo_bit_out(blo), .op_class_out(cls), .opcode_out(opc),
		.op_start_out(st), .op_refused_out(rf), .rx_byte_out(), .rx_valid_out(),
		.rx_index_out(), .read_take_out(), .frame_end_out());
	snd_spi_master snd_spi_master_inst (.clk_in(clk_in), .so_in(oe ? so : ~so),
		.cs_n_out(cs_n), .sck_out(sck), .si_out(si));
	task automatic stop_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic ok, input string m);
		compares++;
		if (ok !== 1'b1)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic fr(input logic [7:0] op);
		snd_spi_master_inst.frame(1'b0, op, 1, 8'h8c);
	endtask
	task automatic wait_ready();
		for (int i = 0; i < 5000 && (rdy !== 1'b1 || hsb_n !== 1'b1); i++)
			@(negedge clk_in);
	endtask
	always @(negedge clk_in)
	begin
		cyc++;
		if (st === 1'b1)
			n_st++;
		if (rf === 1'b1)
			n_rf++;
		if (oe === 1'b1)
			n_oe++;
		if (cyc == 40000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	initial
	begin
		repeat (12) @(negedge clk_in);
		rstn_in = 1'b1;
		repeat (10) @(negedge clk_in);
		chk(hsb_n === 1'b0 && rdy === 1'b0, "busy while restoring");
		fr(8'h9f);
		chk(n_rf == 1, "access during restore");
		wait_ready();
		repeat (int'(STANDBY_CNT) + 2) @(negedge clk_in);
		chk(stby === 1'b1 && act === 1'b0, "standby when deselected");
		foreach (rows[i])
		begin
			fr(8'h06);
			fr(rows[i].op);
			chk(opc === rows[i].op && cls === rows[i].c, "opcode class");
			chk(wel === rows[i].w, "write latch after frame");
			wait_ready();
		end
		fr(8'h05);
		chk(snd_spi_master_inst.rx_r === 8'h8e, "status byte");
		fr(8'h9f);
		chk(snd_spi_master_inst.rx_r === 8'h3a, "ident byte");
		fr(8'hb9);
		chk(slp === 1'b1, "sleep");
		n0 = n_st + n_oe;
		fr(8'h1e);
		chk(n_st + n_oe == n0 && slp === 1'b0, "reserved opcode");
		fr(8'h04);
		n0 = n_rf;
		fr(8'h02);
		chk(n_rf == n0 + 1 && wel === 1'b0, "write without latch");
		snd_spi_master_inst.frame(1'b1, 8'h06, 0, 8'h00);
		chk(m3 === 1'b1 && wel === 1'b1, "mode 3 latch set");
		fr(8'h59);
		fr(8'h06);
		snd_spi_master_inst.frame(1'b0, 8'h01, 1, 8'h00);
		pg = 1'b0;
		hold_n = 1'b0;
		repeat (20) @(negedge clk_in);
		n0 = n_st;
		fr(8'h06);
		chk(n_st == n0, "answer with power low");
		repeat (2300) @(negedge clk_in);
		pg = 1'b1;
		repeat (10) @(negedge clk_in);
		chk(wel === 1'b0 && hold === 1'b0, "state after power up");
		hold_n = 1'b1;
		wait_ready();
		chk(pe === 1'b0 && bhi === 1'b0 && blo === 1'b0 && ase === 1'b1, "saved bits");
		stop_test();
	end
endmodule
